// File: src/instrument_command_parser.v
`include "cmd_parser_map.vh"
module instrument_command_parser (
  // clock and reset
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // incoming byte stream from the host interface
  input  wire        rx_valid_i,
  input  wire [7:0]  rx_data_i,
  input  wire        rx_end_i,
  output wire        rx_ready_o,
  // instruction out, one per instruction, released at the semicolon or terminator
  output reg         instr_valid_o,
  output reg  [3:0]  instr_subsys_o,
  output reg  [3:0]  instr_func_o,
  output reg         instr_query_o,
  output reg         instr_common_o,
  output reg  [3:0]  instr_param_count_o,
  // query answer path
  input  wire        answer_load_i,
  input  wire [7:0]  answer_data_i,
  output reg         tx_valid_o,
  output reg  [7:0]  tx_data_o,
  input  wire        tx_ready_i,
  // error queue entry
  output reg         err_valid_o,
  output reg  [1:0]  err_code_o
);
  localparam ST_HDR  = 3'd0;  // collecting header tokens
  localparam ST_WAIT = 3'd1;  // waiting for token match
  localparam ST_SEP  = 3'd2;  // in separator spaces
  localparam ST_DATA = 3'd3;  // in program data
  localparam ST_SKIP = 3'd4;  // bad instruction, skip to ; or end

  reg  [2:0]  state_reg;
  reg  [95:0] tok_reg;
  reg  [3:0]  tok_len_reg;
  reg  [3:0]  ntok_reg;       // tokens in this header
  reg  [3:0]  subsys_reg;     // current subsystem context
  reg  [3:0]  func_reg;
  reg         query_reg;
  reg         common_reg;
  reg         root_reg;       // header began with a colon
  reg         msg_start_reg;  // no instruction seen yet in this message
  reg         after_semi_reg;
  reg  [3:0]  pcount_reg;
  reg         pdata_reg;      // non-space data seen in current parameter
  reg  [7:0]  pend_byte_reg;  // delimiter that ended the last token
  reg         pend_end_reg;
  reg         bad_reg;
  reg         ans_pend_reg;   // answer loaded but not yet read
  reg         tok_go_reg;
  reg         exec_pend_reg;  // ; or terminator seen, instruction waiting for release
  wire        hit_valid;
  wire [3:0]  sym;

  // upper-case folding so matching ignores case
  wire [7:0] up_byte = (rx_data_i >= 8'h61 && rx_data_i <= 8'h7a) ?
                       (rx_data_i - 8'h20) : rx_data_i;
  wire is_term = (rx_data_i == `CH_NL) | rx_end_i;
  wire is_delim = (rx_data_i == `CH_COLON) | (rx_data_i == `CH_SPACE) |
                  (rx_data_i == `CH_SEMI) | (rx_data_i == `CH_QUERY) | is_term;

  // stall while the matcher works and while an instruction is released,
  // so the byte after a semicolon is never taken and then dropped
  assign rx_ready_o = (state_reg != ST_WAIT) && !tok_go_reg && !exec_pend_reg;
  wire take = rx_valid_i & rx_ready_o;

  token_matcher u_match (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .tok_valid_i (tok_go_reg),
    .tok_i       (tok_reg),
    .tok_len_i   (tok_len_reg),
    .hit_valid_o (hit_valid),
    .sym_o       (sym)
  );

  // parser state machine
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg      <= ST_HDR;
      tok_reg        <= 96'h0;
      tok_len_reg    <= 4'h0;
      ntok_reg       <= 4'h0;
      subsys_reg     <= `SYM_NONE;
      func_reg       <= `SYM_NONE;
      query_reg      <= 1'b0;
      common_reg     <= 1'b0;
      root_reg       <= 1'b0;
      msg_start_reg  <= 1'b1;
      after_semi_reg <= 1'b0;
      pcount_reg     <= 4'h0;
      pdata_reg      <= 1'b0;
      pend_byte_reg  <= 8'h00;
      pend_end_reg   <= 1'b0;
      bad_reg        <= 1'b0;
      tok_go_reg     <= 1'b0;
      exec_pend_reg  <= 1'b0;
      instr_valid_o  <= 1'b0;
      instr_subsys_o <= 4'h0;
      instr_func_o   <= 4'h0;
      instr_query_o  <= 1'b0;
      instr_common_o <= 1'b0;
      instr_param_count_o <= 4'h0;
      err_valid_o    <= 1'b0;
      err_code_o     <= `ERR_NONE;
    end else begin
      instr_valid_o <= 1'b0;
      err_valid_o   <= 1'b0;
      tok_go_reg    <= 1'b0;
      // first byte of a new message while an answer is unread
      if (take && msg_start_reg && ntok_reg == 4'h0 && tok_len_reg == 4'h0 &&
          ans_pend_reg && !is_term) begin
        err_valid_o <= 1'b1;
        err_code_o  <= `ERR_QINT;
      end
      case (state_reg)
        ST_HDR: if (take) begin
          if (rx_data_i == `CH_STAR && tok_len_reg == 4'h0 && ntok_reg == 4'h0)
            common_reg <= 1'b1;           // asterisk must touch the name
          else if (rx_data_i == `CH_COLON && tok_len_reg == 4'h0 && ntok_reg == 4'h0)
            root_reg <= 1'b1;             // leading colon selects the root
          else if (is_delim) begin
            if (tok_len_reg == 4'h0 && !is_term) begin
              bad_reg <= 1'b1;            // empty token or stray delimiter
              state_reg <= ST_SKIP;
            end else if (tok_len_reg != 4'h0) begin
              tok_go_reg    <= 1'b1;      // close token on colon, space, ?, ; or terminator
              pend_byte_reg <= rx_data_i;
              pend_end_reg  <= is_term;
              state_reg     <= ST_WAIT;
            end else begin
              // bare terminator: end of message, back to root
              msg_start_reg <= 1'b1;
              subsys_reg    <= `SYM_NONE;
            end
          end else if (tok_len_reg < `TOK_MAX) begin
            tok_reg     <= {tok_reg[87:0], up_byte};
            tok_len_reg <= tok_len_reg + 4'h1;
          end else begin
            bad_reg   <= 1'b1;
            state_reg <= ST_SKIP;
          end
        end
        ST_WAIT: if (hit_valid) begin
          tok_reg     <= 96'h0;
          tok_len_reg <= 4'h0;
          ntok_reg    <= ntok_reg + 4'h1;
          if (sym == `SYM_NONE) begin
            bad_reg <= 1'b1;              // unknown mnemonic
          end else if (pend_byte_reg == `CH_COLON) begin
            subsys_reg <= sym;            // token before a colon picks subsystem
          end else begin
            func_reg <= sym;              // last token is the function
            if (ntok_reg == 4'h0 && !common_reg && !root_reg && !msg_start_reg &&
                !after_semi_reg)
              bad_reg <= 1'b1;            // bare mnemonic mid-message
            if (ntok_reg == 4'h0 && !common_reg && root_reg)
              subsys_reg <= `SYM_NONE;    // colon after semicolon: root
          end
          if (pend_byte_reg == `CH_QUERY)
            query_reg <= 1'b1;            // trailing ? marks a query
          if (pend_byte_reg == `CH_COLON)
            state_reg <= ST_HDR;
          else if (pend_byte_reg == `CH_QUERY || pend_byte_reg == `CH_SPACE)
            state_reg <= ST_SEP;          // data may follow at once, no space needed
          else
            state_reg <= ST_SEP;
          if (pend_byte_reg == `CH_SEMI || pend_end_reg)
            exec_pend_reg <= 1'b1;        // no data: header ends instruction
        end
        ST_SEP, ST_DATA: begin
          if (exec_pend_reg) begin
            exec_pend_reg <= 1'b0;
            if (bad_reg || subsys_reg == `SYM_NONE && ntok_reg > 4'h1) begin
              err_valid_o <= 1'b1;
              err_code_o  <= `ERR_CMD;
            end else begin
              // released once the header and data are complete
              instr_valid_o       <= 1'b1;
              instr_subsys_o      <= subsys_reg;  // context from earlier
              instr_func_o        <= func_reg;
              instr_query_o       <= query_reg;
              instr_common_o      <= common_reg;
              instr_param_count_o <= pcount_reg + {3'h0, pdata_reg};
            end
            ntok_reg   <= 4'h0;
            query_reg  <= 1'b0;
            common_reg <= 1'b0;
            root_reg   <= 1'b0;
            bad_reg    <= 1'b0;
            pcount_reg <= 4'h0;
            pdata_reg  <= 1'b0;
            msg_start_reg  <= pend_end_reg;
            after_semi_reg <= !pend_end_reg;
            if (pend_end_reg)
              subsys_reg <= `SYM_NONE;    // next message starts at root
            state_reg <= ST_HDR;
          end else if (take) begin
            if (is_term || rx_data_i == `CH_SEMI) begin
              pend_end_reg  <= is_term;
              exec_pend_reg <= 1'b1;
            end else if (rx_data_i == `CH_COMMA) begin
              pcount_reg <= pcount_reg + 4'h1;  // next parameter
              pdata_reg  <= 1'b0;
              state_reg  <= ST_SEP;
            end else if (rx_data_i != `CH_SPACE) begin
              pdata_reg <= 1'b1;          // spaces around commas are dropped
              state_reg <= ST_DATA;
            end
          end
        end
        ST_SKIP: begin
          if (exec_pend_reg) begin
            exec_pend_reg <= 1'b0;
            err_valid_o   <= 1'b1;
            err_code_o    <= `ERR_CMD;    // instruction ignored
            ntok_reg   <= 4'h0;
            tok_reg    <= 96'h0;
            tok_len_reg <= 4'h0;
            query_reg  <= 1'b0;
            common_reg <= 1'b0;
            root_reg   <= 1'b0;
            bad_reg    <= 1'b0;
            pcount_reg <= 4'h0;
            pdata_reg  <= 1'b0;
            msg_start_reg  <= pend_end_reg;
            after_semi_reg <= !pend_end_reg;
            if (pend_end_reg)
              subsys_reg <= `SYM_NONE;
            state_reg <= ST_HDR;
          end else if (take && (is_term || rx_data_i == `CH_SEMI)) begin
            pend_end_reg  <= is_term;
            exec_pend_reg <= 1'b1;
          end
        end
        default: state_reg <= ST_HDR;
      endcase
    end
  end

  // one-byte output queue; a new message discards an unread answer
  wire discard = take && msg_start_reg && ntok_reg == 4'h0 &&
                 tok_len_reg == 4'h0 && !is_term;
  wire [7:0] ans_up = (answer_data_i >= 8'h61 && answer_data_i <= 8'h7a) ?
                      (answer_data_i - 8'h20) : answer_data_i;
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      ans_pend_reg <= 1'b0;
      tx_valid_o   <= 1'b0;
      tx_data_o    <= 8'h00;
    end else if (answer_load_i) begin
      ans_pend_reg <= 1'b1;
      tx_valid_o   <= 1'b1;
      tx_data_o    <= ans_up;           // responses forced to upper case
    end else if (discard || (tx_valid_o && tx_ready_i)) begin
      ans_pend_reg <= 1'b0;
      tx_valid_o   <= 1'b0;
    end
  end
endmodule

// File: include/cmd_parser_map.vh
`ifndef CMD_PARSER_MAP_VH
`define CMD_PARSER_MAP_VH
// character codes
`define CH_COLON    8'h3a
`define CH_QUERY    8'h3f
`define CH_SPACE    8'h20
`define CH_COMMA    8'h2c
`define CH_SEMI     8'h3b
`define CH_STAR     8'h2a
`define CH_NL       8'h0a
// token limits and symbol widths
`define TOK_MAX     4'd12
`define SYM_W       4
`define SYM_NONE    4'h0
// error codes loaded into the error output
`define ERR_NONE    2'd0
`define ERR_CMD     2'd1
`define ERR_QINT    2'd2
`define ERR_SYNTAX  2'd3
`endif

// File: src/token_matcher.v
`include "cmd_parser_map.vh"
// matches an upper-cased token against a small built-in mnemonic table,
// long form or short form; result is registered one cycle after tok_valid_i
module token_matcher (
  // clock and reset
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // token in
  input  wire        tok_valid_i,
  input  wire [95:0] tok_i,
  input  wire [3:0]  tok_len_i,
  // match out
  output reg         hit_valid_o,
  output reg  [3:0]  sym_o
);
  // table: the token arrives right-aligned and zero padded, since the parser
  // shifts each byte in at the bottom; long or short spelling both hit
  function [3:0] lookup;
    input [95:0] t;
    input [3:0]  n;
    reg   [3:0]  r;
    begin
      r = `SYM_NONE;
      if ((t == {24'h0, "AUTOSCALE"} && n == 4'd9) || (t == {72'h0, "AUT"} && n == 4'd3))
        r = 4'h1;
      if ((t == {32'h0, "DIGITIZE"} && n == 4'd8) || (t == {72'h0, "DIG"} && n == 4'd3))
        r = 4'h2;
      // vertical_input_one_selector, long and short spelling as character codes
      if ((t == {32'h0, 64'h4348_414e_4e45_4c31} && n == 4'd8) ||
          (t == {56'h0, 40'h4348_414e_31} && n == 4'd5))
        r = 4'h3;
      if ((t == {32'h0, "TIMEBASE"} && n == 4'd8) || (t == {72'h0, "TIM"} && n == 4'd3))
        r = 4'h4;
      if ((t == {56'h0, "RANGE"} && n == 4'd5) || (t == {64'h0, "RANG"} && n == 4'd4))
        r = 4'h5;
      if ((t == {56'h0, "DELAY"} && n == 4'd5) || (t == {72'h0, "DEL"} && n == 4'd3))
        r = 4'h6;
      if ((t == {48'h0, "OFFSET"} && n == 4'd6) || (t == {64'h0, "OFFS"} && n == 4'd4))
        r = 4'h7;
      if (t == {72'h0, "CLS"} && n == 4'd3)
        r = 4'h8;
      if (t == {72'h0, "RST"} && n == 4'd3)
        r = 4'h9;
      lookup = r;
    end
  endfunction

  // one-cycle registered lookup
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      hit_valid_o <= 1'b0;
      sym_o       <= `SYM_NONE;
    end else begin
      hit_valid_o <= tok_valid_i;
      sym_o       <= tok_valid_i ? lookup(tok_i, tok_len_i) : `SYM_NONE;
    end
  end
endmodule

// File: sim/instrument_command_parser_asserts.sv
`include "cmd_parser_map.vh"
module cmd_parser_checker (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  // byte stream
  input wire logic       rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic       rx_end_i,
  input wire logic       rx_ready_o,
  // instruction and error reports
  input wire logic       instr_valid_o,
  input wire logic [3:0] instr_subsys_o,
  input wire logic [3:0] instr_func_o,
  input wire logic       err_valid_o,
  input wire logic [1:0] err_code_o,
  // answer path
  input wire logic       answer_load_i,
  input wire logic [7:0] answer_data_i,
  input wire logic       tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_ready_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [7:0] up_reg;
  logic       qint_hit;
  // folded copy of the answer byte, so the output can be checked a cycle later
  always @(posedge clk_i) begin
    up_reg <= (answer_data_i inside {[8'h61:8'h7a]}) ? answer_data_i - 8'h20 : answer_data_i;
  end
  // a new byte arriving while an answer is still unread
  assign qint_hit = tx_valid_o && !tx_ready_i && !answer_load_i && rx_valid_i && rx_ready_o
                    && rx_data_i != `CH_NL && !rx_end_i;
  a_instr_one_pulse: assert property (instr_valid_o |=> !instr_valid_o)
    else $error("instruction report longer than one cycle");
  a_qint_discard: assert property (qint_hit |=> !tx_valid_o)
    else $error("unread answer not discarded");
  a_qint_logged: assert property (qint_hit |-> ##[1:2] (err_valid_o && err_code_o == `ERR_QINT))
    else $error("query interrupted not reported");
  a_answer_upper: assert property (answer_load_i |=> tx_valid_o && tx_data_o == up_reg)
    else $error("answer byte not loaded in upper case");
  a_answer_holds: assert property (tx_valid_o && !tx_ready_i && !answer_load_i && !rx_valid_i
    |=> tx_valid_o && $stable(tx_data_o))
    else $error("answer lost while waiting");
  a_answer_taken: assert property (tx_valid_o && tx_ready_i && !answer_load_i |=> !tx_valid_o)
    else $error("answer still offered after read");
  a_err_code_legal: assert property (err_valid_o |-> err_code_o inside {`ERR_CMD, `ERR_QINT})
    else $error("unexpected error code");
  a_compound_func: assert property (instr_valid_o && instr_subsys_o != `SYM_NONE
    |-> instr_func_o != `SYM_NONE)
    else $error("subsystem without function");
  a_query_match: assert property (rx_valid_i && rx_ready_o && rx_data_i == `CH_QUERY
    |=> !rx_ready_o [*2])
    else $error("no match stall after query mark");
endmodule
bind instrument_command_parser cmd_parser_checker chk (
  .clk_i, .sys_rst_i, .rx_valid_i, .rx_data_i, .rx_end_i, .rx_ready_o, .instr_valid_o,
  .instr_subsys_o, .instr_func_o, .err_valid_o, .err_code_o, .answer_load_i,
  .answer_data_i, .tx_valid_o, .tx_data_o, .tx_ready_i
);

// File: sim/cmd_host_model.sv
module cmd_host_model (
  // clock
  input  wire logic       clk_i,
  // bytes toward the parser
  output logic            valid_o = 1'b0,
  output logic [7:0]      data_o = 8'h55,
  output logic            end_o = 1'b0,
  input  wire logic       ready_i,
  // answers from the parser
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] q[$];
  logic [7:0] rsp[$];
  logic       stall = 1'b0;
  logic       slow = 1'b0;
  // queue a whole message; with eoi the last byte also carries the end flag
  task automatic send(input string s, input bit eoi);
    for (int i = 0; i < s.len(); i++) q.push_back({eoi && i == s.len() - 1, s[i]});
  endtask
  // a byte stays put until taken; idle data toggles so stale values never look valid
  always @(posedge clk_i) begin
    if (valid_o && ready_i) void'(q.pop_front());
    valid_o <= q.size() != 0;
    {end_o, data_o} <= (q.size() != 0) ? q[0] : {1'b0, ~data_o};
    if (tx_valid_i && tx_ready_o) rsp.push_back(tx_data_i);
    // answers are read before the next message unless a test holds them back
    tx_ready_o <= !stall && (!slow || !tx_ready_o);
  end
endmodule

// File: sim/instrument_command_parser_bench.sv
module instrument_command_parser_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       answer_load_i = 1'b0;
  logic [7:0] answer_data_i = 8'h00;
  logic       rx_valid_i, rx_end_i, rx_ready_o, tx_valid_o, tx_ready_i;
  logic       instr_valid_o, instr_query_o, instr_common_o, err_valid_o;
  logic [7:0] rx_data_i, tx_data_o;
  logic [3:0] instr_subsys_o, instr_func_o, instr_param_count_o;
  logic [1:0] err_code_o;
  int         n_fail = 0;
  int         num_checks = 0;
  int         seed = 32'hc889;
  logic [14:0] exp_q[$];
  logic [14:0] obs_q[$];
  always #10 clk_i = ~clk_i;
  instrument_command_parser dut (
    .clk_i, .sys_rst_i, .rx_valid_i, .rx_data_i, .rx_end_i, .rx_ready_o, .instr_valid_o,
    .instr_subsys_o, .instr_func_o, .instr_query_o, .instr_common_o, .instr_param_count_o,
    .answer_load_i, .answer_data_i, .tx_valid_o, .tx_data_o, .tx_ready_i, .err_valid_o,
    .err_code_o
  );
  cmd_host_model ctl (
    .clk_i, .valid_o(rx_valid_i), .data_o(rx_data_i), .end_o(rx_end_i), .ready_i(rx_ready_o),
    .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i)
  );
  // every report of the design is logged in arrival order
  always @(posedge clk_i) begin
    if (instr_valid_o) obs_q.push_back({1'b0, instr_subsys_o, instr_func_o, instr_query_o,
                                        instr_common_o, instr_param_count_o});
    if (err_valid_o) obs_q.push_back(15'h4000 | 15'(err_code_o));
  end
  function automatic void want(int s, int f, int q, int c, int n);
    exp_q.push_back({1'b0, 4'(s), 4'(f), 1'(q), 1'(c), 4'(n)});
  endfunction
  function automatic void want_err(int c);
    exp_q.push_back(15'h4000 | 15'(c));
  endfunction
  task automatic check(input logic [14:0] got, input logic [14:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // send one message, let it drain, then compare reports one for one
  task automatic run(input string m, input bit eoi);
    int k;
    k = 0;
    ctl.send(m, eoi);
    while ((ctl.q.size() != 0 || rx_valid_i) && k < 500) begin
      @(posedge clk_i);
      k++;
    end
    repeat (8) @(posedge clk_i);
    check(15'(obs_q.size()), 15'(exp_q.size()));
    while (exp_q.size() != 0 && obs_q.size() != 0)
      check(obs_q.pop_front(), exp_q.pop_front());
    exp_q.delete();
    obs_q.delete();
    $display("test done, %0d checks so far", num_checks);
  endtask
  task automatic answer(input logic [7:0] d);
    answer_data_i <= d;
    answer_load_i <= 1'b1;
    @(posedge clk_i);
    answer_load_i <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // a hang ends the run the same way the tests do
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    print_verdict();
  end
  initial begin
    string s;
    int n;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    want(4, 5, 0, 0, 1);
    run(":TIMEBASE:RANGE 1\n", 0);
    want(4, 6, 0, 0, 3);
    run("tim:dEl 1 ,2, 3\n", 0);
    want(4, 5, 0, 0, 1);
    want(4, 6, 0, 0, 1);
    run(":TIM:RANG 1;DEL 2\n", 0);
    want(4, 5, 0, 0, 1);
    want(0, 1, 0, 0, 0);
    run(":TIM:RANGE 1;:AUTOSCALE\n", 0);
    want(0, 2, 0, 0, 0);
    run("DIG\n", 0);
    want_err(1);
    run(":BOGUS 1\n", 0);
    // the terminator drops the subsystem, so the second function stands at root
    want(4, 5, 0, 0, 1);
    want(0, 6, 0, 0, 1);
    run(":TIM:RANG 1\nDEL 1\n", 0);
    want_err(1);
    run("* CLS\n", 0);
    want(0, 8, 0, 1, 0);
    run("*cls\n", 0);
    want(0, 1, 0, 0, 0);
    run(":AUTOSCALE ", 1);
    // slow reader; a lower-case answer must come back upper case
    ctl.slow = 1'b1;
    want(4, 5, 1, 0, 0);
    run(":TimeBase:RANG?\n", 0);
    answer(8'h6b);
    repeat (10) @(posedge clk_i);
    check(15'(ctl.rsp.pop_front()), 15'h004b);
    // answer left unread while the next message arrives
    ctl.stall = 1'b1;
    want(4, 6, 1, 0, 0);
    run(":TIM:DEL?\n", 0);
    answer(8'h31);
    want_err(2);
    want(0, 9, 0, 1, 0);
    run("*RST\n", 0);
    ctl.stall = 1'b0;
    repeat (10) @(posedge clk_i);
    check(15'(ctl.rsp.size()), 15'h0000);
    // random lists of one to four values
    for (int i = 0; i < 6; i++) begin
      n = 1 + $unsigned($random(seed)) % 4;
      s = ":TIM:OFFSET ";
      for (int j = 0; j < n; j++) begin
        if (j != 0) s = {s, ","};
        s = $sformatf("%s%0d", s, $unsigned($random(seed)) % 10);
      end
      want(4, 7, 0, 0, n);
      run({s, "\n"}, 0);
    end
    print_verdict();
  end
endmodule
